/* shared/cir_pkg.sv */
// constants and types shared by the caller-id receiver control logic
package cir_pkg;

  // core clock
  localparam int CLK_HZ = 200_000_000;
  localparam int CLK_PER_US = CLK_HZ / 1_000_000;

  // fsk character timing
  localparam int BAUD_HZ = 1200;
  localparam int BIT_CYCLES = CLK_HZ / BAUD_HZ;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] BIT_IDX_LAST = 4'h7;

  // alerting-tone guard times, in microseconds, then in cycles
  localparam int TONE_PRESENT_GUARD_US = 40_000;
  localparam int TONE_ABSENT_GUARD_US = 0;
  localparam int TONE_PRESENT_CYCLES_RAW = TONE_PRESENT_GUARD_US * CLK_PER_US;
  localparam int TONE_ABSENT_CYCLES_RAW = TONE_ABSENT_GUARD_US * CLK_PER_US;
  localparam int TONE_PRESENT_CYCLES =
    (TONE_PRESENT_CYCLES_RAW < 1) ? 1 : TONE_PRESENT_CYCLES_RAW;
  localparam int TONE_ABSENT_CYCLES =
    (TONE_ABSENT_CYCLES_RAW < 1) ? 1 : TONE_ABSENT_CYCLES_RAW;

  // counter width for all long timers
  localparam int TMR_W = 24;
  localparam logic [TMR_W-1:0] TMR_ZERO = 24'h00_0000;
  localparam logic [TMR_W-1:0] TMR_ONE = 24'h00_0001;

  // synchronised pin inputs, index into the synchroniser vector
  localparam int SYNC_N = 8;
  localparam int SI_CTRL_A = 0;
  localparam int SI_CTRL_B = 1;
  localparam int SI_CTRL_C = 2;
  localparam int SI_LINE_BIT = 3;
  localparam int SI_CARRIER = 4;
  localparam int SI_LINE_TONE = 5;
  localparam int SI_HSET_TONE = 6;
  localparam int SI_SHIFT_CLK = 7;

  // holding buffer: eight data bits plus the stop bit
  localparam int HOLD_W = 9;
  localparam logic [HOLD_W-1:0] HOLD_IDLE = 9'h1ff;

  typedef enum logic [1:0] {
    CIR_RX_IDLE = 2'h0,
    CIR_RX_START = 2'h1,
    CIR_RX_DATA = 2'h3,
    CIR_RX_STOP = 2'h2
  } cir_rx_state_t;

endpackage

/* logic/cir_tone_guard.sv */
// tone-present / tone-absent guard timer for the alerting-tone detector
`timescale 1ns/1ps
module cir_tone_guard
  import cir_pkg::*;
#(
  parameter logic [TMR_W-1:0] P_PRESENT_CYCLES = TMR_W'(TONE_PRESENT_CYCLES),
  parameter logic [TMR_W-1:0] P_ABSENT_CYCLES = TMR_W'(TONE_ABSENT_CYCLES)
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // detector control and raw indication
  input wire logic i_enable,
  input wire logic i_raw_dual_tone_present,
  // result, low while a valid alert is recognised
  output logic o_tone_detected_n
);

  logic [TMR_W-1:0] tmr_reg;
  logic [TMR_W-1:0] tmr_next;
  logic det_reg;
  logic det_next;

  // while undetected count tone presence, while detected count tone absence
  wire logic counting = det_reg ? ~i_raw_dual_tone_present : i_raw_dual_tone_present;
  wire logic limit_hit = det_reg ? (tmr_reg + TMR_ONE >= P_ABSENT_CYCLES)
                                 : (tmr_reg + TMR_ONE >= P_PRESENT_CYCLES);

  always_comb begin
    tmr_next = TMR_ZERO;
    det_next = det_reg;
    if (!i_enable) begin
      det_next = 1'b0;
    end else if (counting) begin
      // any break in the condition restarts the count from zero
      if (limit_hit) begin
        det_next = ~det_reg;
      end else begin
        tmr_next = tmr_reg + TMR_ONE;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      tmr_reg <= TMR_ZERO;
      det_reg <= 1'b0;
    end else begin
      tmr_reg <= tmr_next;
      det_reg <= det_next;
    end
  end

  assign o_tone_detected_n = ~det_reg;

endmodule

/* logic/cir_caller_id_rx.sv */
// caller-id receiver: function select, input routing, power control, fsk output
`timescale 1ns/1ps
module cir_caller_id_rx
  import cir_pkg::*;
#(
  parameter logic [TMR_W-1:0] P_BIT_CYCLES = TMR_W'(BIT_CYCLES),
  parameter logic [TMR_W-1:0] P_TONE_PRESENT_CYCLES = TMR_W'(TONE_PRESENT_CYCLES),
  parameter logic [TMR_W-1:0] P_TONE_ABSENT_CYCLES = TMR_W'(TONE_ABSENT_CYCLES)
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // function control pins from the host
  input wire logic i_ctrl_pin_a,
  input wire logic i_ctrl_pin_b,
  input wire logic i_ctrl_pin_c,
  // line-side and handset-side detector results
  input wire logic i_line_fsk_bit,
  input wire logic i_line_carrier,
  input wire logic i_line_raw_dual_tone_present,
  input wire logic i_handset_raw_dual_tone_present,
  // host read-out clock for the holding buffer
  input wire logic i_host_shift_clk,
  // host-facing data and status
  output logic o_fsk_data,
  output logic o_data_ready_or_tone_flag_pin,
  output logic o_bit_sample,
  output logic o_end_of_char,
  output logic o_carrier_detect_n,
  // power enables
  output logic o_line_amp_en,
  output logic o_handset_amp_en,
  output logic o_fsk_en,
  output logic o_tone_det_en,
  output logic o_osc_en
);

  // two-stage synchronisers for every pin input
  logic [SYNC_N-1:0] sync1_reg;
  logic [SYNC_N-1:0] sync2_reg;
  wire logic [SYNC_N-1:0] pins_in = {i_host_shift_clk, i_handset_raw_dual_tone_present,
                                     i_line_raw_dual_tone_present, i_line_carrier,
                                     i_line_fsk_bit, i_ctrl_pin_c, i_ctrl_pin_b,
                                     i_ctrl_pin_a};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
      always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= pins_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  // function decode
  wire logic pin_a = sync2_reg[SI_CTRL_A];
  wire logic pin_b = sync2_reg[SI_CTRL_B];
  wire logic pin_c = sync2_reg[SI_CTRL_C];
  wire logic fn_fsk = pin_b & pin_c;
  wire logic fn_hset_tone = pin_b & ~pin_c;
  wire logic fn_line_tone = ~pin_b & pin_c;
  // the all-zero code is reserved; it is handled as power down so nothing runs
  wire logic fn_power_down = ~pin_b & ~pin_c;
  wire logic fn_tone = fn_hset_tone | fn_line_tone;
  wire logic buffer_mode = fn_fsk & ~pin_a;

  // routing: fsk only ever sees the line path, handset only reaches the tone detector
  wire logic fsk_bit = sync2_reg[SI_LINE_BIT];
  wire logic tone_raw = fn_hset_tone ? sync2_reg[SI_HSET_TONE]
                      : fn_line_tone ? sync2_reg[SI_LINE_TONE] : 1'b0;
  wire logic carrier_ok = fn_fsk & sync2_reg[SI_CARRIER];

  // host shift clock rising edge, taken from the second stage only
  logic shift_d_reg;
  wire logic shift_edge = sync2_reg[SI_SHIFT_CLK] & ~shift_d_reg;

  // character receiver
  cir_rx_state_t state_reg;
  cir_rx_state_t state_next;
  logic [TMR_W-1:0] tmr_reg;
  logic [TMR_W-1:0] tmr_next;
  logic [3:0] bit_idx_reg;
  logic [3:0] bit_idx_next;
  logic [DATA_BITS-1:0] byte_reg;
  logic [DATA_BITS-1:0] byte_next;
  logic sample_pulse;
  logic char_done;

  wire logic [TMR_W-1:0] half_bit = P_BIT_CYCLES >> 1;
  wire logic tmr_done = (tmr_reg == TMR_ONE);

  always_comb begin
    state_next = state_reg;
    tmr_next = (tmr_reg == TMR_ZERO) ? TMR_ZERO : tmr_reg - TMR_ONE;
    bit_idx_next = bit_idx_reg;
    byte_next = byte_reg;
    sample_pulse = 1'b0;
    char_done = 1'b0;
    case (state_reg)
      CIR_RX_IDLE: begin
        if (!fsk_bit) begin
          state_next = CIR_RX_START;
          tmr_next = half_bit;
        end
      end
      CIR_RX_START: begin
        // a start bit that has gone by mid-bit was a glitch
        if (tmr_done) begin
          state_next = fsk_bit ? CIR_RX_IDLE : CIR_RX_DATA;
          tmr_next = P_BIT_CYCLES;
          bit_idx_next = 4'h0;
        end
      end
      CIR_RX_DATA: begin
        if (tmr_done) begin
          sample_pulse = 1'b1;
          byte_next = {fsk_bit, byte_reg[DATA_BITS-1:1]};
          tmr_next = P_BIT_CYCLES;
          bit_idx_next = bit_idx_reg + 4'h1;
          if (bit_idx_reg == BIT_IDX_LAST) begin
            state_next = CIR_RX_STOP;
          end
        end
      end
      CIR_RX_STOP: begin
        if (tmr_done) begin
          char_done = 1'b1;
          state_next = CIR_RX_IDLE;
        end
      end
      default: begin
        state_next = CIR_RX_IDLE;
      end
    endcase
    // without carrier, or outside fsk, the receiver is held idle
    if (!carrier_ok) begin
      state_next = CIR_RX_IDLE;
      tmr_next = TMR_ZERO;
      sample_pulse = 1'b0;
      char_done = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_reg <= CIR_RX_IDLE;
      tmr_reg <= TMR_ZERO;
      bit_idx_reg <= 4'h0;
      byte_reg <= 8'h00;
      shift_d_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
      bit_idx_reg <= bit_idx_next;
      byte_reg <= byte_next;
      shift_d_reg <= sync2_reg[SI_SHIFT_CLK];
    end
  end

  // one-byte holding buffer with its stop bit; host shifts it out lsb first
  logic [HOLD_W-1:0] hold_reg;
  logic [HOLD_W-1:0] hold_next;
  wire logic capture = char_done & buffer_mode;
  wire logic do_shift = shift_edge & buffer_mode;

  always_comb begin
    hold_next = hold_reg;
    if (capture) begin
      hold_next = {fsk_bit, byte_reg};
    end else if (do_shift) begin
      hold_next = {1'b1, hold_reg[HOLD_W-1:1]};
    end
  end

  // data-ready: set by a finished character, cleared by a read or a new start
  logic ready_reg;
  wire logic ready_clr = do_shift | (state_reg != CIR_RX_IDLE) | ~fn_fsk;
  // a new character beats a clear in the same cycle
  wire logic ready_next = char_done | (ready_reg & ~ready_clr);

  // tone detection and its guard time
  logic tone_detected_n;

  cir_tone_guard #(
    .P_PRESENT_CYCLES(P_TONE_PRESENT_CYCLES),
    .P_ABSENT_CYCLES(P_TONE_ABSENT_CYCLES)
  ) u_tone_guard (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_enable(fn_tone),
    .i_raw_dual_tone_present(tone_raw),
    .o_tone_detected_n(tone_detected_n)
  );

  // output data: buffer bit, live stream gated by carrier, or idle mark
  wire logic data_next = buffer_mode ? hold_reg[0]
                       : (carrier_ok ? fsk_bit : 1'b1);
  wire logic pin_next = fn_tone ? tone_detected_n : ~ready_reg;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      hold_reg <= HOLD_IDLE;
      ready_reg <= 1'b0;
      o_fsk_data <= 1'b1;
      o_data_ready_or_tone_flag_pin <= 1'b1;
      o_bit_sample <= 1'b0;
      o_end_of_char <= 1'b0;
      o_carrier_detect_n <= 1'b1;
      o_line_amp_en <= 1'b0;
      o_handset_amp_en <= 1'b0;
      o_fsk_en <= 1'b0;
      o_tone_det_en <= 1'b0;
      o_osc_en <= 1'b0;
    end else begin
      hold_reg <= hold_next;
      ready_reg <= ready_next;
      o_fsk_data <= data_next;
      o_data_ready_or_tone_flag_pin <= pin_next;
      o_bit_sample <= sample_pulse & ~buffer_mode;
      o_end_of_char <= char_done & ~buffer_mode;
      o_carrier_detect_n <= ~carrier_ok;
      o_line_amp_en <= fn_fsk | fn_line_tone;
      o_handset_amp_en <= fn_hset_tone;
      o_fsk_en <= fn_fsk;
      o_tone_det_en <= fn_tone;
      o_osc_en <= ~fn_power_down;
    end
  end

endmodule

/* tb/cir_caller_id_rx_chk.sv */
// port assertions for the caller-id receiver
`timescale 1ns/1ps
module cir_caller_id_rx_chk
  import cir_pkg::*;
#(
  parameter logic [TMR_W-1:0] P_BIT_CYCLES = TMR_W'(BIT_CYCLES),
  parameter logic [TMR_W-1:0] P_TONE_PRESENT_CYCLES = TMR_W'(TONE_PRESENT_CYCLES),
  parameter logic [TMR_W-1:0] P_TONE_ABSENT_CYCLES = TMR_W'(TONE_ABSENT_CYCLES)
) (
  // clock, reset and pins
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ctrl_pin_a,
  input wire logic i_ctrl_pin_b,
  input wire logic i_ctrl_pin_c,
  input wire logic i_line_fsk_bit,
  input wire logic i_line_carrier,
  input wire logic i_line_raw_dual_tone_present,
  input wire logic i_handset_raw_dual_tone_present,
  input wire logic i_host_shift_clk,
  // outputs watched
  input wire logic o_fsk_data,
  input wire logic o_data_ready_or_tone_flag_pin,
  input wire logic o_bit_sample,
  input wire logic o_end_of_char,
  input wire logic o_carrier_detect_n,
  input wire logic o_line_amp_en,
  input wire logic o_handset_amp_en,
  input wire logic o_fsk_en,
  input wire logic o_tone_det_en,
  input wire logic o_osc_en
);
  logic tone_sel;
  logic [TMR_W-1:0] run_reg;
  logic [TMR_W-1:0] gap_reg;
  // raw tone run length, counted ahead of the design's synchronised copy
  assign tone_sel = o_handset_amp_en ? i_handset_raw_dual_tone_present
                                     : i_line_raw_dual_tone_present;
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !tone_sel || !o_tone_det_en) run_reg <= TMR_ZERO;
    else if (run_reg != '1) run_reg <= run_reg + TMR_ONE;
  end
  // cycles since the last sample strobe; a counter keeps a long bit time cheap
  always_ff @(posedge i_core_clk) begin
    if (i_rst) gap_reg <= TMR_ZERO;
    else if (o_bit_sample) gap_reg <= TMR_ONE;
    else if (gap_reg != '1) gap_reg <= gap_reg + TMR_ONE;
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // four steady samples cover sync plus output register
  sequence s_pd; (!i_ctrl_pin_b && !i_ctrl_pin_c) [*4]; endsequence
  sequence s_fsk; (i_ctrl_pin_b && i_ctrl_pin_c) [*4]; endsequence
  sequence s_hset; (i_ctrl_pin_b && !i_ctrl_pin_c) [*4]; endsequence
  sequence s_line; (!i_ctrl_pin_b && i_ctrl_pin_c) [*4]; endsequence
  a_pd_all_off:
    assert property (s_pd |=> !o_osc_en && !o_fsk_en && !o_tone_det_en && !o_line_amp_en
      && !o_handset_amp_en) else $error("power down left a block on");
  a_fsk_tone_off:
    assert property (s_fsk |=> o_fsk_en && !o_tone_det_en && o_line_amp_en
      && !o_handset_amp_en) else $error("fsk mode enables wrong");
  a_hset_fsk_off:
    assert property (s_hset |=> !o_fsk_en && o_tone_det_en && o_handset_amp_en
      && !o_line_amp_en) else $error("handset tone mode enables wrong");
  a_line_tone_sel:
    assert property (s_line |=> !o_fsk_en && o_tone_det_en && o_line_amp_en
      && !o_handset_amp_en) else $error("line tone mode enables wrong");
  a_strobe_idle:
    assert property (!o_fsk_en [*3] |-> !o_bit_sample && !o_end_of_char)
      else $error("strobe outside fsk mode");
  a_stream_mute:
    assert property ((i_ctrl_pin_a && !i_line_carrier) [*6] |-> o_fsk_data && !o_bit_sample
      && !o_end_of_char) else $error("data not muted without carrier");
  a_carrier_flag:
    assert property ((i_ctrl_pin_b && i_ctrl_pin_c && i_line_carrier) [*5]
      |-> !o_carrier_detect_n) else $error("carrier flag missing");
  a_eoc_spacing:
    assert property (o_end_of_char |-> gap_reg == P_BIT_CYCLES)
      else $error("end strobe not one bit after last sample");
  a_tone_guard:
    assert property ($fell(o_data_ready_or_tone_flag_pin) && o_tone_det_en
      |-> run_reg >= P_TONE_PRESENT_CYCLES) else $error("tone flag before guard time");
  a_tone_release:
    assert property (o_tone_det_en && !o_data_ready_or_tone_flag_pin && !tone_sel
      |-> ##[1:10] o_data_ready_or_tone_flag_pin) else $error("tone flag stuck low");
endmodule

bind cir_caller_id_rx cir_caller_id_rx_chk #(
  .P_BIT_CYCLES(P_BIT_CYCLES),
  .P_TONE_PRESENT_CYCLES(P_TONE_PRESENT_CYCLES),
  .P_TONE_ABSENT_CYCLES(P_TONE_ABSENT_CYCLES)
) u_chk (.*);

/* tb/cir_host_model.sv */
// host microcontroller model: function pins and buffer read clock
`timescale 1ns/1ps
module cir_host_model (
  // clock
  input wire logic i_core_clk,
  // pins toward the receiver
  output logic o_ctrl_pin_a,
  output logic o_ctrl_pin_b,
  output logic o_ctrl_pin_c,
  output logic o_host_shift_clk
);
  initial begin
    o_ctrl_pin_a = 1'h1;
    o_ctrl_pin_b = 1'h0;
    o_ctrl_pin_c = 1'h0;
    o_host_shift_clk = 1'h0;
  end
  // the all-zero pattern is for factory test, so a is forced high with b=c=0
  task automatic set_fn(input logic a, input logic b, input logic c);
    @(negedge i_core_clk);
    o_ctrl_pin_a = a || !(b || c);
    o_ctrl_pin_b = b;
    o_ctrl_pin_c = c;
  endtask
  // one read clock, w cycles high then w low; w sets a quick or slow host
  task automatic shift(input int w);
    @(negedge i_core_clk);
    o_host_shift_clk = 1'h1;
    repeat (w) @(negedge i_core_clk);
    o_host_shift_clk = 1'h0;
    repeat (w) @(negedge i_core_clk);
  endtask
endmodule

/* tb/tb_caller_id_rx_mode_and_output.sv */
// self-checking bench for the caller-id receiver control block
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin total_checks++; if ((sn) !== (ex)) begin bad_count++; \
  $display("ERROR %s expected %h seen %h", nm, ex, sn); end end
module tb_caller_id_rx_mode_and_output;
  import cir_pkg::*;
  localparam int TB_BIT = 32'h0000_0028;
  localparam int TB_TONE = 32'h0000_0032;
  // enables {osc,line,hset,fsk,tone} for b,c = 00,01,10,11
  localparam logic [19:0] EN_TAB = 20'hd_5720;
  logic clk;
  logic rst = 1'h1;
  logic lbit = 1'h1;
  logic carr = 1'h0;
  logic ltone = 1'h0;
  logic htone = 1'h0;
  logic ca, cb, cc, sclk;
  logic fsk_data, pin, samp, eoc, cd_n, l_en, h_en, f_en, t_en, o_en;
  int bad_count = 0;
  int total_checks = 0;
  int n_samp = 0;
  int n_eoc = 0;
  logic [7:0] got = 8'h00;
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  cir_host_model host (.i_core_clk(clk), .o_ctrl_pin_a(ca), .o_ctrl_pin_b(cb),
    .o_ctrl_pin_c(cc), .o_host_shift_clk(sclk));
  cir_caller_id_rx #(
    .P_BIT_CYCLES(TMR_W'(TB_BIT)),
    .P_TONE_PRESENT_CYCLES(TMR_W'(TB_TONE)),
    .P_TONE_ABSENT_CYCLES(24'h00_0001)
  ) DUT (
    .i_core_clk(clk), .i_rst(rst), .i_ctrl_pin_a(ca), .i_ctrl_pin_b(cb), .i_ctrl_pin_c(cc),
    .i_line_fsk_bit(lbit), .i_line_carrier(carr), .i_line_raw_dual_tone_present(ltone),
    .i_handset_raw_dual_tone_present(htone), .i_host_shift_clk(sclk),
    .o_fsk_data(fsk_data), .o_data_ready_or_tone_flag_pin(pin), .o_bit_sample(samp),
    .o_end_of_char(eoc), .o_carrier_detect_n(cd_n), .o_line_amp_en(l_en),
    .o_handset_amp_en(h_en), .o_fsk_en(f_en), .o_tone_det_en(t_en), .o_osc_en(o_en)
  );
  // stream bits gathered at each sample strobe, lsb first
  always @(posedge clk) begin
    if (samp === 1'h1) begin
      n_samp++;
      got = {fsk_data, got[7:1]};
    end
    if (eoc === 1'h1) n_eoc++;
  end
  task automatic results;
    if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wait_pin(input logic v, input int lim);
    int k = 0;
    while (pin !== v && k < lim) begin
      @(negedge clk);
      k++;
    end
    if (pin !== v) begin
      bad_count++;
      $display("ERROR pin expected %h seen %h", v, pin);
      results();
    end
  endtask
  // start bit and eight data bits; the caller owns the stop bit
  task automatic send_char(input logic [7:0] d);
    logic [8:0] fr;
    fr = {d, 1'h0};
    for (int i = 0; i < 9; i++) begin
      lbit = fr[i];
      repeat (TB_BIT) @(negedge clk);
    end
  endtask
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      host.set_fn(1'h1, m[1], m[0]);
      repeat (6) @(negedge clk);
      `CHK("enables", EN_TAB[m*5 +: 5], {o_en, l_en, h_en, f_en, t_en})
    end
  endtask
  task automatic t_stream;
    host.set_fn(1'h1, 1'h1, 1'h1);
    carr = 1'h1;
    repeat (8) @(negedge clk);
    `CHK("carrier_n", 1'h0, cd_n)
    n_samp = 0;
    send_char(8'ha5);
    lbit = 1'h1;
    repeat (TB_BIT) @(negedge clk);
    `CHK("byte 1", 8'ha5, got)
    send_char(8'h3c);
    lbit = 1'h1;
    repeat (TB_BIT) @(negedge clk);
    `CHK("byte 2", 8'h3c, got)
    `CHK("samples", 16, n_samp)
    `CHK("ends", 2, n_eoc)
    carr = 1'h0;
    n_samp = 0;
    send_char(8'h00);
    `CHK("muted", 1'h1, fsk_data)
    `CHK("no strobes", 0, n_samp)
    lbit = 1'h1;
  endtask
  task automatic t_buffer;
    logic [8:0] rd;
    host.set_fn(1'h0, 1'h1, 1'h1);
    carr = 1'h1;
    repeat (8) @(negedge clk);
    n_samp = 0;
    send_char(8'h96);
    // a low stop bit proves the stop slot is really stored
    lbit = 1'h0;
    wait_pin(1'h0, 2 * TB_BIT);
    lbit = 1'h1;
    for (int i = 0; i < 9; i++) begin
      repeat (4) @(negedge clk);
      rd[i] = fsk_data;
      host.shift(2 + 2 * (i % 2));
    end
    `CHK("buffer", 9'h096, rd)
    `CHK("buffer strobes", 0, n_samp)
  endtask
  task automatic t_tone;
    host.set_fn(1'h1, 1'h1, 1'h0);
    repeat (8) @(negedge clk);
    ltone = 1'h1;
    repeat (TB_TONE + 20) @(negedge clk);
    `CHK("line ignored", 1'h1, pin)
    htone = 1'h1;
    repeat (TB_TONE - 10) @(negedge clk);
    htone = 1'h0;
    @(negedge clk);
    htone = 1'h1;
    repeat (TB_TONE - 10) @(negedge clk);
    `CHK("early flag", 1'h1, pin)
    wait_pin(1'h0, 30);
    htone = 1'h0;
    wait_pin(1'h1, 10);
    host.set_fn(1'h1, 1'h0, 1'h1);
    wait_pin(1'h0, TB_TONE + 20);
    ltone = 1'h0;
    wait_pin(1'h1, 10);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'h0;
    t_modes();
    t_stream();
    t_buffer();
    t_tone();
    results();
  end
endmodule
